// ===== design/bint_core.sv
// prescaler and 8-bit up counter of the basic interval timer
`timescale 1ns/1ps
`default_nettype none
module bint_core
	import bint_pkg::*;
#(
	parameter int unsigned CNT_W = BINT_CNT_W  // counter width
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	input  wire logic                   run_en,
	input  wire logic [BINT_RATE_W-1:0] rate,
	input  wire logic                   load,
	input  wire logic [CNT_W-1:0]       load_val,
	output logic      [CNT_W-1:0]       count,
	output logic                        ovf
);
	logic [CNT_W-1:0] pre_reg;   // prescaler, counts instruction clocks
	logic [CNT_W-1:0] pre_next;
	logic [CNT_W-1:0] cnt_reg;   // the visible count
	logic [CNT_W-1:0] cnt_next;
	logic [CNT_W-1:0] pre_mask;  // low bits that must all be one for a tick
	logic             tick;      // one counting-clock edge

	// code 0 divides by 256, each step halves the divisor
	assign pre_mask = BINT_PRE_ALL >> rate;
	// no tick while stopped, so a stopped timer never overflows
	assign tick     = run_en && ((pre_reg & pre_mask) == pre_mask);
	// overflow is lost to a software load in the same cycle; the load wins
	assign ovf      = ce && tick && !load && (cnt_reg == BINT_CNT_MAX);
	assign count    = cnt_reg;

	// next prescaler and counter values
	always_comb begin
		pre_next = pre_reg;
		cnt_next = cnt_reg;
		if (!run_en) begin
			pre_next = '0; // restart phase on the next enable
		end else begin
			pre_next = pre_reg + BINT_CNT_ONE;
		end
		if (load) begin
			cnt_next = load_val; // direct preset
		end else if (tick) begin
			cnt_next = cnt_reg + BINT_CNT_ONE; // wraps to zero and keeps going
		end
	end

	// registers, frozen while the clock enable is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg <= '0;
			cnt_reg <= BINT_CNT_RST;
		end else if (ce) begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_fast_tick;
		tick && (rate == 3'h7) && run_en && ce;
	endsequence
	// timer still running at the fastest rate and clocked this cycle
	sequence s_fast_run;
		ce && run_en && (rate == 3'h7);
	endsequence

	AST_WRAP_ZERO: assert property (ovf |=> cnt_reg == BINT_CNT_RST)
		else $error("count did not wrap to zero after overflow");
	AST_HOLD_STOPPED: assert property (ce && !run_en && !load |=> $stable(cnt_reg))
		else $error("count moved while stopped");
	AST_STEP_ONE: assert property (ce && tick && !load |=> cnt_reg == $past(cnt_reg) + BINT_CNT_ONE)
		else $error("count did not step by one on a tick");
	AST_LOAD_VALUE: assert property (ce && load |=> cnt_reg == $past(load_val))
		else $error("load value not taken");
	// a stop or a rate change right after the gap cycle ends the check instead of firing it
	AST_DIV2_SPACING: assert property (s_fast_tick ##1 s_fast_run |-> !tick)
		else $error("divide-by-two spacing broken");
	AST_DIV2_SEQ: assert property (s_fast_tick ##1 s_fast_run ##1 s_fast_run |-> tick)
		else $error("divide-by-two sequence broken");
endmodule // bint_core
`default_nettype wire

// ===== design/bint_pkg.sv
// constants and register map of the basic interval timer
package bint_pkg;
	localparam int unsigned         BINT_ADDR_W     = 12;      // apb byte address width
	localparam int unsigned         BINT_DATA_W     = 32;      // apb data width
	localparam int unsigned         BINT_CNT_W      = 8;       // counter and prescaler width
	localparam int unsigned         BINT_RATE_W     = 3;       // prescale select width
	// register indices as printed; byte address is four times the index
	localparam logic [9:0]          BINT_IDX_MODE   = 10'h0D8; // timer_mode_control
	localparam logic [9:0]          BINT_IDX_COUNT  = 10'h0D9; // timer_count_value
	localparam logic [9:0]          BINT_IDX_STAT   = 10'h0DA; // overflow request flag
	localparam logic [9:0]          BINT_IDX_MASK   = 10'h0DB; // interrupt enable
	// mode register field layout
	localparam int unsigned         BINT_EN_BIT     = 7;       // run enable
	localparam int unsigned         BINT_RATE_MSB   = 6;       // prescale select high bit
	localparam int unsigned         BINT_RATE_LSB   = 4;       // prescale select low bit
	localparam logic [7:0]          BINT_MODE_FIXED = 8'h08;   // bit 3 reads as one
	localparam int unsigned         BINT_FLAG_BIT   = 0;       // flag position in status and mask
	// reset values
	localparam logic [2:0]          BINT_RATE_RST   = 3'h0;    // fcpu/256
	localparam logic [7:0]          BINT_CNT_RST    = 8'h00;
	localparam logic [7:0]          BINT_PRE_ALL    = 8'hFF;   // prescaler mask for /256
	localparam logic [7:0]          BINT_CNT_MAX    = 8'hFF;   // last count before wrap
	localparam logic [7:0]          BINT_CNT_ONE    = 8'h01;
	localparam logic [31:0]         BINT_ZERO_WORD  = 32'h0000_0000;
endpackage : bint_pkg

// ===== design/bint_top.sv
// apb register block and interrupt logic of the basic interval timer
//
// Contract
// - 8-bit up counter, wraps and keeps counting
// - timeout wakes green mode while run enabled
// - mode bit 7 run enable, resets zero
// - bits 6:4 select fcpu/256 down to /2
// - count register readable, writable, loads counter
// - overflow always sets flag; enable gates interrupt
`timescale 1ns/1ps
`default_nettype none
module bint_top
	import bint_pkg::*;
#(
	parameter int unsigned CNT_W = BINT_CNT_W  // counter width
) (
	input  wire logic                   CORE_CLK,
	input  wire logic                   NRST,
	input  wire logic                   CE,
	input  wire logic                   PSEL,
	input  wire logic                   PENABLE,
	input  wire logic                   PWRITE,
	input  wire logic [BINT_ADDR_W-1:0] PADDR,
	input  wire logic [BINT_DATA_W-1:0] PWDATA,
	output logic      [BINT_DATA_W-1:0] PRDATA,
	output logic                        PREADY,
	output logic                        PSLVERR,
	output logic                        IRQ,
	output logic                        WAKE_REQ
);
	logic                   sync1_reg;         // reset release, first stage
	logic                   rst_n;             // reset release, second stage
	logic                   run_en_reg;        // timer_run_enable
	logic                   run_en_next;
	logic [BINT_RATE_W-1:0] rate_reg;          // timer_prescale_select
	logic [BINT_RATE_W-1:0] rate_next;
	logic                   flag_reg;          // timer_overflow_request_flag
	logic                   flag_next;
	logic                   ien_reg;           // timer_interrupt_enable
	logic                   ien_next;
	logic [BINT_DATA_W-1:0] rdata_reg;         // read data held for the access phase
	logic [BINT_DATA_W-1:0] rdata_next;
	logic                   err_reg;           // unmapped address seen in setup
	logic                   err_next;
	logic [9:0]             idx;               // word index of the address
	logic                   hit_mode;
	logic                   hit_count;
	logic                   hit_stat;
	logic                   hit_mask;
	logic                   mapped;
	logic                   wr;                // write takes effect this edge
	logic                   setup;             // apb setup cycle
	logic [CNT_W-1:0]       count;
	logic                   ovf;
	logic [7:0]             mode_rd;

	// reset: asserts at once, releases after two clean edges
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			sync1_reg <= 1'b0;
			rst_n     <= 1'b0;
		end else begin
			sync1_reg <= 1'b1;
			rst_n     <= sync1_reg;
		end
	end

	// address decode; the low two bits are ignored, words are aligned
	assign idx       = PADDR[BINT_ADDR_W-1:2];
	assign hit_mode  = (idx == BINT_IDX_MODE);
	assign hit_count = (idx == BINT_IDX_COUNT);
	assign hit_stat  = (idx == BINT_IDX_STAT);
	assign hit_mask  = (idx == BINT_IDX_MASK);
	assign mapped    = hit_mode || hit_count || hit_stat || hit_mask;
	assign setup     = PSEL && !PENABLE;
	// no wait states; an unmapped write is dropped and flagged
	assign wr        = PSEL && PENABLE && PWRITE && mapped && CE;
	assign PREADY    = 1'b1;
	assign PRDATA    = rdata_reg;
	assign PSLVERR   = PSEL && PENABLE && err_reg;

	// mode readback: run enable, rate, bit 3 fixed at one
	always_comb begin
		mode_rd                              = BINT_MODE_FIXED;
		mode_rd[BINT_EN_BIT]                 = run_en_reg;
		mode_rd[BINT_RATE_MSB:BINT_RATE_LSB] = rate_reg;
	end

	// next values of the control and status bits
	always_comb begin
		run_en_next = run_en_reg;
		rate_next   = rate_reg;
		ien_next    = ien_reg;
		flag_next   = flag_reg;
		if (wr && hit_mode) begin
			run_en_next = PWDATA[BINT_EN_BIT];
			rate_next   = PWDATA[BINT_RATE_MSB:BINT_RATE_LSB];
		end
		if (wr && hit_mask) begin
			ien_next = PWDATA[BINT_FLAG_BIT];
		end
		if (wr && hit_stat && PWDATA[BINT_FLAG_BIT]) begin
			flag_next = 1'b0;                                        // write one to clear
		end
		// set beats a clear landing in the same cycle, enable or not
		if (ovf) begin
			flag_next = 1'b1;
		end
	end

	// read data is sampled in the setup cycle and held through access
	always_comb begin
		rdata_next = rdata_reg;
		err_next   = err_reg;
		if (setup) begin
			err_next   = !mapped;
			rdata_next = BINT_ZERO_WORD;
			if (!PWRITE) begin
				if (hit_mode) begin
					rdata_next[7:0] = mode_rd;
				end else if (hit_count) begin
					rdata_next[CNT_W-1:0] = count;
				end else if (hit_stat) begin
					rdata_next[BINT_FLAG_BIT] = flag_reg;
				end else if (hit_mask) begin
					rdata_next[BINT_FLAG_BIT] = ien_reg;
				end
			end
		end
	end

	// register stage, frozen while the clock enable is low
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			run_en_reg <= 1'b0;
			rate_reg   <= BINT_RATE_RST;
			flag_reg   <= 1'b0;
			ien_reg    <= 1'b0;
			rdata_reg  <= BINT_ZERO_WORD;
			err_reg    <= 1'b0;
		end else if (CE) begin
			run_en_reg <= run_en_next;
			rate_reg   <= rate_next;
			flag_reg   <= flag_next;
			ien_reg    <= ien_next;
			rdata_reg  <= rdata_next;
			err_reg    <= err_next;
		end
	end

	// level interrupt only while flag and enable are both set
	assign IRQ      = flag_reg && ien_reg;
	// overflow only happens while running, so this is the green-mode wake
	assign WAKE_REQ = ovf && run_en_reg;

	// counting engine; software write loads the counter directly
	bint_core #(
		.CNT_W    (CNT_W)
	) i_bint_core (
		.clk      (CORE_CLK),
		.rst_n    (rst_n),
		.ce       (CE),
		.run_en   (run_en_reg),
		.rate     (rate_reg),
		.load     (wr && hit_count),
		.load_val (PWDATA[CNT_W-1:0]),
		.count    (count),
		.ovf      (ovf)
	);

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!rst_n);

	sequence s_mode_write;
		wr && hit_mode;
	endsequence

	AST_FLAG_ON_OVF: assert property (ovf |=> flag_reg)
		else $error("overflow did not set the flag");
	AST_FLAG_NOT_IEN: assert property (ovf && !ien_reg && !(wr && hit_mask) |=> flag_reg && !IRQ)
		else $error("flag or interrupt wrong with enable low");
	AST_IRQ_GATED: assert property (!ien_reg |-> !IRQ)
		else $error("interrupt raised while disabled");
	AST_RUN_READBACK: assert property (s_mode_write |=> run_en_reg == $past(PWDATA[BINT_EN_BIT]))
		else $error("run enable not written");
	AST_RATE_WRITE: assert property (s_mode_write |=> rate_reg == $past(PWDATA[BINT_RATE_MSB:BINT_RATE_LSB]))
		else $error("prescale select not written");
	// every overflow wakes, and no wake comes without a running timer
	AST_WAKE_ONLY_RUN: assert property ((WAKE_REQ == ovf) && (!WAKE_REQ || run_en_reg))
		else $error("wake without running timer");
	AST_NO_OVF_STOPPED: assert property (!run_en_reg |-> !ovf)
		else $error("overflow while stopped");
	AST_CLEAR_FLAG: assert property (CE && wr && hit_stat && PWDATA[BINT_FLAG_BIT] && !ovf |=> !flag_reg)
		else $error("flag not cleared by write of one");
endmodule // bint_top
`default_nettype wire

// ===== dv/bint_top_tb.sv
// self-checking testbench of the basic interval timer
`timescale 1ns/1ps
`default_nettype none
module bint_top_tb;
	import bint_pkg::*;
	localparam int unsigned LIMIT  = 20000;                  // cycle ceiling, run needs about 2300
	localparam logic [11:0] A_MODE = {BINT_IDX_MODE, 2'b00};  // mode register byte address
	localparam logic [11:0] A_CNT  = {BINT_IDX_COUNT, 2'b00}; // count register byte address
	localparam logic [11:0] A_STAT = {BINT_IDX_STAT, 2'b00};  // status register byte address
	localparam logic [11:0] A_MASK = {BINT_IDX_MASK, 2'b00};  // mask register byte address
	localparam logic [11:0] A_BAD  = 12'h3F0;                 // unmapped word
	logic        clk, nrst, ce, psel, penable, pwrite, pready, pslverr, irq, wake, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          miscompares = 0, compares = 0, cyc = 0, wake_cnt = 0, last_wake = 0;
	int          t_en, te, p, d, w0;

	bint_top i_bint_top (.CORE_CLK(clk), .NRST(nrst), .CE(ce), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .IRQ(irq), .WAKE_REQ(wake));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// edge index, wake pulse log and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wake === 1'b1) begin
			wake_cnt  <= wake_cnt + 1;
			last_wake <= cyc;
		end
		if (cyc == LIMIT) begin
			miscompares = miscompares + 1;
			complete_run();
		end
	end

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t word got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t bit got %b expected %b", $time, got, exp);
		end
	endtask

	// one apb transfer; entered just after an edge, request held until pready is seen
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= data;
		@(posedge clk);
		penable <= 1'b1;
		// pready ends this wait; only the cycle ceiling ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd   = prdata;
		err  = pslverr;
		t_en = cyc;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// wait for the next wake pulse; a hang is caught by the cycle ceiling
	task automatic wait_wake();
		w0 = wake_cnt;
		while (wake_cnt == w0) begin
			@(posedge clk);
		end
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		ce = 1'b1;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		// reset is released through two flops inside, so give it three edges
		repeat (3) @(posedge clk);
		apb(0, A_MODE, 0); cmp_word(rd, 32'h0000_0008);
		apb(0, A_CNT, 0); cmp_word(rd, 32'h0000_0000);
		apb(0, A_STAT, 0); cmp_word(rd, 32'h0000_0000);
		cmp_bit(irq, 1'b0);
		apb(0, A_BAD, 0); cmp_word(rd, 32'h0000_0000);
		cmp_bit(err, 1'b1);
		done("reset_and_map");
		// every prescale code, preset two steps short of the wrap
		for (int r = 0; r < 8; r++) begin
			apb(1, A_MODE, 0);
			apb(1, A_STAT, 1);
			apb(1, A_CNT, 32'h0000_00FE);
			apb(1, A_MODE, 32'h80 | (r << 4));
			te = t_en;
			apb(0, A_MODE, 0); cmp_word(rd, 32'h88 | (r << 4));
			p = 256 >> r;
			if (wake_cnt == 0 || last_wake < te) wait_wake();
			d = last_wake - te;
			cmp_bit(d >= 2 * p - 3 && d <= 2 * p + 1, 1'b1);
			apb(0, A_STAT, 0); cmp_word(rd, 32'h0000_0001);
			cmp_bit(irq, 1'b0);
			apb(0, A_CNT, 0); cmp_bit(rd[7:0] < 8'h10, 1'b1);
		end
		done("prescale_overflow");
		// interrupt enable gates the level output, flag is write-one-to-clear
		apb(1, A_MASK, 1); cmp_bit(irq, 1'b1);
		apb(0, A_MASK, 0); cmp_word(rd, 32'h0000_0001);
		apb(1, A_STAT, 1); cmp_bit(irq, 1'b0);
		wait_wake();
		@(posedge clk);
		cmp_bit(irq, 1'b1);
		apb(1, A_MASK, 0); cmp_bit(irq, 1'b0);
		apb(0, A_STAT, 0); cmp_word(rd, 32'h0000_0001);
		done("interrupt");
		// stopped timer must hold its preset and raise no wake
		apb(1, A_MODE, 0);
		apb(1, A_CNT, 32'h0000_00A5);
		w0 = wake_cnt;
		repeat (600) @(posedge clk);
		apb(0, A_CNT, 0); cmp_word(rd, 32'h0000_00A5);
		cmp_bit(wake_cnt == w0, 1'b1);
		// a frozen block ignores the bus
		ce <= 1'b0;
		apb(1, A_CNT, 32'h0000_003C);
		ce <= 1'b1;
		apb(0, A_CNT, 0); cmp_word(rd, 32'h0000_00A5);
		done("hold_and_freeze");
		complete_run();
	end
endmodule // bint_top_tb
`default_nettype wire
